// *** logic/converter_fault_supervisor.sv ***
// converter fault supervisor: input lockout, output protection, thermal shutdown, telemetry
// assumes: measurements arrive synchronous to clock in mV, mA and signed degrees C
`timescale 1ns/1ps
`include "supervisor_map.svh"

module converter_fault_supervisor
  import supervisor_pkg::*;
#(
  parameter int COOLDOWN_CYCLES = `COOLDOWN_TIME_US * `CLOCK_MHZ,
  parameter int WIDTH           = 16
)(
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [7:0]       address,
  input  wire logic [15:0]      writeData,
  input  wire logic             writeStrobe,
  input  wire logic             readStrobe,
  output logic      [15:0]      readData,
  input  wire logic             remoteEnable,
  input  wire logic [WIDTH-1:0] inputVoltage,
  input  wire logic [WIDTH-1:0] outputVoltage,
  input  wire logic [WIDTH-1:0] outputCurrent,
  input  wire logic [WIDTH-1:0] temperature,
  output logic                  outputEnable,
  output logic      [WIDTH-1:0] voltageSetpoint,
  output logic                  interrupt
);
  // cooldown counter wide enough to hold COOLDOWN_CYCLES
  localparam int CW = $clog2(COOLDOWN_CYCLES + 1);

  logic                   resetMeta_n;
  logic                   resetSync_n;
  run_state_type          state;
  run_state_type          next_state;
  logic [CW-1:0]          cooldown;
  logic [`FAULT_COUNT-1:0] activeFault;
  logic [`FAULT_COUNT-1:0] faultLog;
  logic [`FAULT_COUNT-1:0] irqStatus;
  logic [`FAULT_COUNT-1:0] irqMask;
  logic [15:0]            thermalReading;
  logic [15:0]            uvOn;
  logic [15:0]            uvOff;
  logic [15:0]            ovOn;
  logic [15:0]            ovOff;
  logic [15:0]            vSet;
  logic [15:0]            curLimit;
  logic [15:0]            curShut;
  logic [15:0]            thermTrip;
  logic [15:0]            thermHyst;
  logic [15:0]            derateStep;
  logic                   inputAboveUv;
  logic                   inputAboveOv;
  logic                   thermalHot;
  logic [WIDTH-1:0]       setpointNow;
  wire  [`FAULT_COUNT-1:0] next_irqStatus;
  wire  [`FAULT_COUNT-1:0] next_faultLog;

  // reset release through two flip-flops
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resetMeta_n <= 1'b0;
      resetSync_n <= 1'b0;
    end
    else
    begin
      resetMeta_n <= 1'b1;
      resetSync_n <= resetMeta_n;
    end
  end

  // input lockout bands
  hysteresis_band #(.WIDTH(16)) uvBand (
    .clock       (clock),
    .resetSync_n (resetSync_n),
    .sample      (inputVoltage),
    .highLimit   (uvOn),
    .lowLimit    (uvOff),
    .isSigned    (1'b0),
    .above       (inputAboveUv)
  );

  hysteresis_band #(.WIDTH(16)) ovBand (
    .clock       (clock),
    .resetSync_n (resetSync_n),
    .sample      (inputVoltage),
    .highLimit   (ovOff),
    .lowLimit    (ovOn),
    .isSigned    (1'b0),
    .above       (inputAboveOv)
  );

  wire [15:0] thermLow = thermTrip - thermHyst;
  hysteresis_band #(.WIDTH(16)) thermBand (
    .clock       (clock),
    .resetSync_n (resetSync_n),
    .sample      (temperature),
    .highLimit   (thermTrip),
    .lowLimit    (thermLow),
    .isSigned    (1'b1),
    .above       (thermalHot)
  );

  wire running = (state == STATE_RUN);

  // overload is the lower current limit; the shutdown limit acts through curOver
  wire overload = (outputCurrent > curLimit);

  setpoint_derate #(.WIDTH(WIDTH)) derate (
    .clock       (clock),
    .resetSync_n (resetSync_n),
    .nominal     (vSet),
    .step        (derateStep),
    .overload    (overload),
    .running     (running),
    .setpoint    (setpointNow)
  );

  // output window limits follow the programmed setpoint vSet, not the derated one
  wire [18:0] ovpLimit   = 19'((20'(vSet) * `OVP_NUM) / `OVP_DEN);
  wire [15:0] shortLimit = {1'b0, vSet[15:1]};
  wire outOver   = running && ({3'b000, outputVoltage} > ovpLimit);
  wire outShort  = running && (outputVoltage < shortLimit);
  wire curOver   = running && (outputCurrent > curShut);
  wire outFault  = outOver || outShort || curOver;

  wire inputOk   = inputAboveUv && !inputAboveOv;
  wire cooldownDone = (cooldown == '0);

  // thermal shutdown overrides every other state
  always_comb
  begin
    next_state = state;
    unique case (state)
      STATE_OFF:
        if (thermalHot)
          next_state = STATE_THERMAL;
        else if (remoteEnable && inputOk)
          next_state = STATE_RUN;
      STATE_RUN:
        if (thermalHot)
          next_state = STATE_THERMAL;
        else if (!remoteEnable || !inputOk)
          next_state = STATE_OFF;
        else if (outFault)
          next_state = STATE_COOLDOWN;
      STATE_COOLDOWN:
        if (thermalHot)
          next_state = STATE_THERMAL;
        else if (cooldownDone)
          next_state = STATE_OFF;
      STATE_THERMAL:
        if (!thermalHot)
          next_state = STATE_OFF;
      default:
        next_state = STATE_OFF;
    endcase
  end

  // loaded on entry to cooldown, then counts down and holds at zero
  wire cooldownStart = (next_state == STATE_COOLDOWN) && (state != STATE_COOLDOWN);
  wire [CW-1:0] next_cooldown = cooldownStart ?
                                CW'(COOLDOWN_CYCLES) :
                                (cooldownDone ? cooldown : cooldown - 1'b1);

  always_ff @(posedge clock or negedge resetSync_n)
  begin
    if (!resetSync_n)
    begin
      state    <= STATE_OFF;
      cooldown <= '0;
    end
    else
    begin
      state    <= next_state;
      cooldown <= next_cooldown;
    end
  end

  // active faults; output window latches until the retry
  // input faults follow the bands; output faults are checked only while running
  logic outWindowHeld;
  logic curHeld;
  wire [`FAULT_COUNT-1:0] next_activeFault = {
    thermalHot,
    curHeld || curOver,
    outWindowHeld || outOver || outShort,
    inputAboveOv,
    !inputAboveUv
  };

  always_ff @(posedge clock or negedge resetSync_n)
  begin
    if (!resetSync_n)
    begin
      outWindowHeld <= 1'b0;
      curHeld       <= 1'b0;
      activeFault   <= '0;
      faultLog      <= '0;
    end
    else
    begin
      outWindowHeld <= (state == STATE_COOLDOWN) ? (outWindowHeld || outOver || outShort)
                                                 : (outOver || outShort);
      curHeld       <= (state == STATE_COOLDOWN) ? (curHeld || curOver) : curOver;
      activeFault   <= next_activeFault;
      faultLog      <= next_faultLog;
    end
  end

  // telemetry capture
  always_ff @(posedge clock or negedge resetSync_n)
  begin
    if (!resetSync_n)
      thermalReading <= `RESET_READING;
    else
      thermalReading <= temperature;
  end

  // register bus
  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] target);
    return (a == target);
  endfunction : isAddr

  wire hitStatus  = isAddr(address, `ADDR_FAULT_STATUS);
  wire hitTemp    = isAddr(address, `ADDR_THERMAL_READING);
  wire hitIrqStat = isAddr(address, `ADDR_IRQ_STATUS);
  wire hitIrqMask = isAddr(address, `ADDR_IRQ_MASK);
  wire hitCtrl    = isAddr(address, `ADDR_CONTROL);
  wire hitInLim   = isAddr(address, `ADDR_INPUT_LIMITS);
  wire hitUvLim   = isAddr(address, `ADDR_UV_LIMITS);
  wire hitThLim   = isAddr(address, `ADDR_THERMAL_LIMITS);
  wire hitCur     = isAddr(address, `ADDR_OUT_CURRENT);

  // write enables, one per writable register
  wire writeIrqStat = writeStrobe && hitIrqStat;
  wire writeIrqMask = writeStrobe && hitIrqMask;
  wire writeCtrl    = writeStrobe && hitCtrl;
  wire writeInLim   = writeStrobe && hitInLim;
  wire writeUvLim   = writeStrobe && hitUvLim;
  wire writeThLim   = writeStrobe && hitThLim;
  wire writeCur     = writeStrobe && hitCur;

  wire [`FAULT_COUNT-1:0] faultRise = next_activeFault & ~activeFault;
  wire [`FAULT_COUNT-1:0] irqClear  = writeIrqStat ?
                                      writeData[`FAULT_COUNT-1:0] : '0;

  // per-fault sticky bits: a new event wins over an interrupt status clear in the same cycle; remote enable off clears the log regardless
  for (genvar f = 0; f < `FAULT_COUNT; f++)
  begin : faultBit
    assign next_irqStatus[f] = faultRise[f] || (irqStatus[f] && !irqClear[f]);
    assign next_faultLog[f]  = remoteEnable && (faultLog[f] || next_activeFault[f]);
  end

  // under-voltage off, over-voltage on, current limit, hysteresis and step stay fixed
  always_ff @(posedge clock or negedge resetSync_n)
  begin
    if (!resetSync_n)
    begin
      irqStatus  <= '0;
      irqMask    <= '0;
      vSet       <= `RESET_VOUT_SET;
      ovOff      <= `RESET_OV_OFF;
      ovOn       <= `RESET_OV_ON;
      uvOn       <= `RESET_UV_ON;
      uvOff      <= `RESET_UV_OFF;
      thermTrip  <= `RESET_THERM_TRIP;
      thermHyst  <= `RESET_THERM_HYST;
      curLimit   <= `RESET_CUR_LIMIT;
      curShut    <= `RESET_CUR_SHUT;
      derateStep <= `RESET_DERATE_STEP;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      if (writeIrqMask)
        irqMask <= writeData[`FAULT_COUNT-1:0];
      if (writeCtrl)
        vSet <= writeData;
      if (writeInLim)
        ovOff <= writeData;
      if (writeUvLim)
        uvOn <= writeData;
      if (writeThLim)
        thermTrip <= writeData;
      if (writeCur)
        curShut <= writeData;
    end
  end

  wire [15:0] statusWord = {3'b000, faultLog, 3'b000, activeFault};
  // unmapped offsets read as zero; read data stand for one cycle only
  wire [15:0] readMux =
    hitStatus  ? statusWord :
    hitTemp    ? {thermalReading[15:8], thermalReading[7:0]} :
    hitIrqStat ? {11'h000, irqStatus} :
    hitIrqMask ? {11'h000, irqMask} :
    hitCtrl    ? vSet :
    hitInLim   ? ovOff :
    hitUvLim   ? uvOn :
    hitThLim   ? thermTrip :
    hitCur     ? curShut : 16'h0000;

  always_ff @(posedge clock or negedge resetSync_n)
  begin
    if (!resetSync_n)
    begin
      readData        <= 16'h0000;
      outputEnable    <= 1'b0;
      voltageSetpoint <= '0;
      interrupt       <= 1'b0;
    end
    else
    begin
      readData        <= readStrobe ? readMux : 16'h0000;
      // next_state drives the enable so that a stop needs no extra cycle
      outputEnable    <= (next_state == STATE_RUN);
      voltageSetpoint <= setpointNow;
      interrupt       <= |(next_irqStatus & irqMask);
    end
  end
endmodule : converter_fault_supervisor

// *** logic/hysteresis_band.sv ***
// hysteretic comparator: sets above highLimit, clears below lowLimit
// assumes: synchronous inputs, reset synchronised by the caller
`timescale 1ns/1ps
module hysteresis_band
  import supervisor_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic             clock,
  input  wire logic             resetSync_n,
  input  wire logic [WIDTH-1:0] sample,
  input  wire logic [WIDTH-1:0] highLimit,
  input  wire logic [WIDTH-1:0] lowLimit,
  input  wire logic             isSigned,
  output logic                  above
);
  wire aboveHigh = isSigned ? ($signed(sample) > $signed(highLimit)) : (sample > highLimit);
  wire belowLow  = isSigned ? ($signed(sample) < $signed(lowLimit)) : (sample < lowLimit);
  wire next_above = aboveHigh ? 1'b1 : (belowLow ? 1'b0 : above);

  always_ff @(posedge clock or negedge resetSync_n)
  begin
    if (!resetSync_n)
      above <= 1'b0;
    else
      above <= next_above;
  end
endmodule : hysteresis_band

// *** logic/setpoint_derate.sv ***
// output setpoint control: steps down under overload, back up to nominal after
// assumes: one step per clock, nominal setpoint supplied by the caller
`timescale 1ns/1ps
module setpoint_derate
  import supervisor_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic             clock,
  input  wire logic             resetSync_n,
  input  wire logic [WIDTH-1:0] nominal,
  input  wire logic [WIDTH-1:0] step,
  input  wire logic             overload,
  input  wire logic             running,
  output logic      [WIDTH-1:0] setpoint
);
  wire [WIDTH-1:0] lowered = (setpoint > step) ? setpoint - step : '0;
  wire [WIDTH-1:0] raised  = (nominal - setpoint > step) ? setpoint + step : nominal;
  wire [WIDTH-1:0] next_setpoint = !running ? nominal :
                                   overload ? lowered :
                                   (setpoint < nominal) ? raised : nominal;

  always_ff @(posedge clock or negedge resetSync_n)
  begin
    if (!resetSync_n)
      setpoint <= '0;
    else
      setpoint <= next_setpoint;
  end
endmodule : setpoint_derate

// *** logic/supervisor_map.svh ***
// register offsets, field positions, reset values and thresholds of the supervisor
// assumes: included by bare name from the design files
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

`define ADDR_FAULT_STATUS    8'h79
`define ADDR_THERMAL_READING 8'h8d
`define ADDR_IRQ_STATUS      8'h90
`define ADDR_IRQ_MASK        8'h91
`define ADDR_CONTROL         8'h92
`define ADDR_INPUT_LIMITS    8'h93
`define ADDR_UV_LIMITS       8'h94
`define ADDR_THERMAL_LIMITS  8'h95
`define ADDR_OUT_CURRENT     8'h96

`define FAULT_COUNT          5
`define LOG_SHIFT            8
`define BIT_INPUT_LOW        0
`define BIT_INPUT_HIGH       1
`define BIT_OUTPUT_WINDOW    2
`define BIT_OUTPUT_CURRENT   3
`define BIT_THERMAL          4

`define RESET_READING        16'h0000
`define RESET_UV_ON          16'h3c8c
`define RESET_UV_OFF         16'h37dc
`define RESET_OV_ON          16'ha028
`define RESET_OV_OFF         16'ha8c0
`define RESET_VOUT_SET       16'h2ee0
`define RESET_CUR_LIMIT      16'ha000
`define RESET_CUR_SHUT       16'hc350
`define RESET_THERM_TRIP     16'h0073
`define RESET_THERM_HYST     16'h000a
`define RESET_DERATE_STEP    16'h0064

// over-voltage limit is 120 % and short-circuit limit 50 % of the setpoint
`define OVP_NUM              6
`define OVP_DEN              5

`define COOLDOWN_TIME_US     10000
`define CLOCK_MHZ            10
`endif

// *** logic/supervisor_pkg.sv ***
// types of the converter fault supervisor
// assumes: nothing
package supervisor_pkg;
  typedef enum logic [3:0] {
    STATE_OFF      = 4'b0001,
    STATE_RUN      = 4'b0010,
    STATE_COOLDOWN = 4'b0100,
    STATE_THERMAL  = 4'b1000
  } run_state_type;
endpackage : supervisor_pkg

// *** tb/converter_fault_supervisor_tb.sv ***
// self-checking bench for the converter fault supervisor
// assumes: cooldown shortened to 8 cycles, thresholds at reset values
`timescale 1ns/1ps
module converter_fault_supervisor_tb;
  import supervisor_pkg::*;
  logic        clock;
  logic        reset_n;
  logic [7:0]  address;
  logic [15:0] writeData;
  logic        writeStrobe;
  logic        readStrobe;
  logic [15:0] readData;
  logic        remoteEnable;
  logic [15:0] inputVoltage;
  logic [15:0] outputVoltage;
  logic [15:0] outputCurrent;
  logic [15:0] temperature;
  logic        outputEnable;
  logic [15:0] voltageSetpoint;
  logic        interrupt;
  logic [15:0] rd;
  int          nErrors;
  int          testsRun;
  int          cycles = 0;
  logic [15:0] temps [4] = '{16'hffff, 16'hffc9, 16'h1234, 16'h0019};
  logic [15:0] vouts [5] = '{16'h37dc, 16'h38a4, 16'h17d4, 16'h170c, 16'h2ee0};
  logic [15:0] iouts [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hea60};
  logic        trips [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  host_model host (.clock(clock), .readData(readData), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe));
  converter_fault_supervisor #(.COOLDOWN_CYCLES(8), .WIDTH(16)) DUT (.clock(clock),
    .reset_n(reset_n), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .remoteEnable(remoteEnable), .inputVoltage(inputVoltage),
    .outputVoltage(outputVoltage), .outputCurrent(outputCurrent),
    .temperature(temperature), .outputEnable(outputEnable),
    .voltageSetpoint(voltageSetpoint), .interrupt(interrupt));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic completeRun;
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : completeRun

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      nErrors = nErrors + 1;
      completeRun();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun = testsRun + 1;
    if (seen !== exp)
    begin
      nErrors = nErrors + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  task automatic waitOn(input logic exp, input int maxC);
    int n;
    n = 0;
    while (outputEnable !== exp && n < maxC)
    begin
      settle(1);
      n = n + 1;
    end
    check({15'h0, outputEnable}, {15'h0, exp});
  endtask : waitOn

  task automatic readCheck(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
    host.readReg(a, rd);
    check(rd & m, exp);
  endtask : readCheck

  task automatic setVin(input logic [15:0] v);
    @(posedge clock);
    inputVoltage <= v;
  endtask : setVin

  task automatic setOut(input logic [15:0] v, input logic [15:0] i);
    @(posedge clock);
    outputVoltage <= v;
    outputCurrent <= i;
  endtask : setOut

  task automatic setTemp(input logic [15:0] t);
    @(posedge clock);
    temperature <= t;
  endtask : setTemp

  initial
  begin
    reset_n = 1'b0;
    remoteEnable = 1'b0;
    inputVoltage = 16'h0000;
    outputVoltage = 16'h2ee0;
    outputCurrent = 16'h0000;
    temperature = 16'h0019;
    nErrors = 0;
    testsRun = 0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (temps[k])
    begin
      setTemp(temps[k]);
      readCheck(8'h8d, temps[k], 16'hffff);
    end
    host.writeReg(8'h8d, 16'h5555);
    readCheck(8'h8d, 16'h0019, 16'hffff);
    readCheck(8'h00, 16'h0000, 16'hffff);
    @(posedge clock);
    remoteEnable <= 1'b1;
    setVin(16'h3a98);
    settle(6);
    check({15'h0, outputEnable}, 16'h0000);
    setVin(16'h3e80);
    waitOn(1'b1, 6);
    setVin(16'h3a98);
    settle(6);
    check({15'h0, outputEnable}, 16'h0001);
    setVin(16'h36b0);
    waitOn(1'b0, 6);
    readCheck(8'h79, 16'h0101, 16'h0101);
    check({15'h0, interrupt}, 16'h0000);
    setVin(16'h3e80);
    waitOn(1'b1, 6);
    setVin(16'habe0);
    waitOn(1'b0, 6);
    readCheck(8'h79, 16'h0202, 16'h0202);
    setVin(16'ha410);
    settle(6);
    check({15'h0, outputEnable}, 16'h0000);
    setVin(16'h9c40);
    waitOn(1'b1, 6);
    for (int k = 0; k < 5; k++)
    begin
      setOut(vouts[k], iouts[k]);
      settle(3);
      check({15'h0, outputEnable}, {15'h0, !trips[k]});
      setOut(16'h2ee0, 16'h0000);
      if (trips[k])
      begin
        settle(2);
        check({15'h0, outputEnable}, 16'h0000);
        waitOn(1'b1, 30);
      end
    end
    readCheck(8'h79, 16'h0c00, 16'h0c00);
    host.writeReg(8'h92, 16'h2710);
    setOut(16'h2f44, 16'h0000);
    waitOn(1'b0, 6);
    setOut(16'h2328, 16'h0000);
    waitOn(1'b1, 30);
    setOut(16'h157c, 16'h0000);
    settle(3);
    check({15'h0, outputEnable}, 16'h0001);
    setOut(16'h2328, 16'h0000);
    check(voltageSetpoint, 16'h2710);
    setOut(16'h2328, 16'hafc8);
    settle(5);
    check({15'h0, (voltageSetpoint < 16'h2710)}, 16'h0001);
    check({15'h0, outputEnable}, 16'h0001);
    setOut(16'h2328, 16'h0000);
    settle(150);
    check(voltageSetpoint, 16'h2710);
    host.writeReg(8'h90, 16'h001f);
    host.writeReg(8'h91, 16'h0010);
    readCheck(8'h91, 16'h0010, 16'h001f);
    check({15'h0, interrupt}, 16'h0000);
    setTemp(16'h0078);
    waitOn(1'b0, 6);
    settle(2);
    check({15'h0, interrupt}, 16'h0001);
    readCheck(8'h90, 16'h0010, 16'h001f);
    setTemp(16'h006e);
    settle(6);
    check({15'h0, outputEnable}, 16'h0000);
    setTemp(16'h0064);
    waitOn(1'b1, 30);
    host.writeReg(8'h90, 16'h0010);
    settle(2);
    check({15'h0, interrupt}, 16'h0000);
    readCheck(8'h79, 16'h1000, 16'h1000);
    @(posedge clock);
    remoteEnable <= 1'b0;
    waitOn(1'b0, 6);
    readCheck(8'h79, 16'h0000, 16'h1f00);
    readCheck(8'h92, 16'h2710, 16'hffff);
    host.writeReg(8'h93, 16'h1111);
    readCheck(8'h93, 16'h1111, 16'hffff);
    host.writeReg(8'h94, 16'h2222);
    readCheck(8'h94, 16'h2222, 16'hffff);
    host.writeReg(8'h95, 16'h0033);
    readCheck(8'h95, 16'h0033, 16'hffff);
    host.writeReg(8'h96, 16'h4444);
    readCheck(8'h96, 16'h4444, 16'hffff);
    completeRun();
  end
endmodule : converter_fault_supervisor_tb

bind converter_fault_supervisor supervisor_asserts #(.WIDTH(WIDTH)) chk (.clock(clock),
  .reset_n(reset_n), .address(address), .readStrobe(readStrobe), .readData(readData),
  .remoteEnable(remoteEnable), .inputVoltage(inputVoltage), .outputCurrent(outputCurrent),
  .temperature(temperature), .outputEnable(outputEnable), .voltageSetpoint(voltageSetpoint));

// *** tb/host_model.sv ***
// host controller model: register reads and writes over the plain port
// assumes: read data stand in the cycle after the read strobe
`timescale 1ns/1ps
module host_model (
  input  wire logic        clock,
  input  wire logic [15:0] readData,
  output logic      [7:0]  address,
  output logic      [15:0] writeData,
  output logic             writeStrobe,
  output logic             readStrobe
);
  initial
  begin
    address = 8'h00;
    writeData = 16'h0000;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
  end

  task automatic writeReg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : writeReg

  task automatic readReg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1;
    d = readData;
  endtask : readReg
endmodule : host_model

// *** tb/supervisor_asserts.sv ***
// concurrent checks on the supervisor top-level ports
// assumes: bound into converter_fault_supervisor, thresholds at reset values
`timescale 1ns/1ps
module supervisor_asserts #(
  parameter int WIDTH = 16
)(
  input wire logic             clock,
  input wire logic             reset_n,
  input wire logic [7:0]       address,
  input wire logic             readStrobe,
  input wire logic [15:0]      readData,
  input wire logic             remoteEnable,
  input wire logic [WIDTH-1:0] inputVoltage,
  input wire logic [WIDTH-1:0] outputCurrent,
  input wire logic [WIDTH-1:0] temperature,
  input wire logic             outputEnable,
  input wire logic [WIDTH-1:0] voltageSetpoint
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence offRequest;
    !remoteEnable [*2];
  endsequence
  sequence lowInput;
    (inputVoltage < 16'h37dc) [*2];
  endsequence
  sequence highInput;
    (inputVoltage > 16'ha8c0) [*2];
  endsequence
  sequence hot;
    ($signed(temperature) > 16'sh0073) [*2];
  endsequence
  sequence overload;
    (outputEnable && outputCurrent > 16'ha000 && outputCurrent <= 16'hc350) [*3];
  endsequence

  a_read_idle: assert property (!$past(readStrobe) |-> readData == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_temp_read: assert property (readStrobe && address == 8'h8d |=> readData == $past(temperature, 2))
    else $error("temperature read differs from sample");
  a_remote_off: assert property (offRequest |=> !outputEnable)
    else $error("output on while remote enable off");
  a_uv_stop: assert property (lowInput |=> !outputEnable)
    else $error("output on below under-voltage turn-off");
  a_ov_stop: assert property (highInput |=> !outputEnable)
    else $error("output on above over-voltage turn-off");
  a_current_shut: assert property (outputEnable && outputCurrent > 16'hc350 |-> ##2 !outputEnable)
    else $error("output not stopped on over-current");
  a_thermal_off: assert property (hot |=> !outputEnable)
    else $error("output on above thermal trip");
  a_derate_step: assert property (overload |=>
      voltageSetpoint < $past(voltageSetpoint) || $past(voltageSetpoint) < 16'h0064)
    else $error("setpoint not lowered under overload");
  a_start_guard: assert property ($rose(outputEnable) |->
      $past(remoteEnable) && $past(inputVoltage, 2) >= 16'h37dc)
    else $error("output started without valid input");
endmodule : supervisor_asserts
